//--- csf_pkg.sv
// Shared constants and types for the core special-function registers
package csf_pkg;
	localparam int DW = 8;
	localparam int PC_W = 12;
	localparam int PM_W = 15;
	localparam int PRE_SEL_W = 3;
	localparam int PRE_W = 7;

	// Data-memory locations
	localparam logic [7:0] A_PC_LOW = 8'h06;
	localparam logic [7:0] A_TBL_PTR = 8'h07;
	localparam logic [7:0] A_TBL_HIGH = 8'h08;
	localparam logic [7:0] A_WD_PRESCALE = 8'h09;
	localparam logic [7:0] A_STAT = 8'h0A;
	localparam logic [7:0] A_IRQ0 = 8'h0B;
	localparam logic [7:0] A_DIRA = 8'h13;
	localparam logic [7:0] A_DIRB = 8'h15;
	localparam logic [7:0] A_DIRC = 8'h17;
	localparam logic [7:0] A_DIRD = 8'h19;
	localparam logic [7:0] A_IRQ1 = 8'h1E;
	localparam logic [7:0] A_IRQM = 8'h1F;

	// Flag register bit positions
	localparam int F_C = 0;
	localparam int F_NIB_WRAP = 1;
	localparam int F_Z = 2;
	localparam int F_SGN_WRAP = 3;
	localparam int F_PWR_DOWN = 4;
	localparam int F_WD_EXPIRY = 5;
	// Global enable sits in bit 0 of the first irq control register
	localparam int F_GIE = 0;
	localparam int NIBBLE = 4;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_WD_PRESCALE = 8'h07;
	localparam logic [7:0] UNUSED_RD = 8'h00;

	typedef enum logic [1:0] {
		ALU_ADD = 2'b00,
		ALU_SUB = 2'b01,
		ALU_LOGIC = 2'b10,
		ALU_ROT = 2'b11
	} csf_alu_t;

	typedef enum logic {
		TBL_IDLE = 1'b0,
		TBL_FETCH = 1'b1
	} csf_tbl_t;
endpackage

//--- csf_wdt_if.sv
// Link between the register bank and its watchdog counter
`timescale 1ns/1ps
interface csf_wdt_if;
	logic clear;
	logic [csf_pkg::PRE_SEL_W-1:0] prescale_sel;
	logic timeout;

	modport bank (output clear, output prescale_sel, input timeout);
	modport timer (input clear, input prescale_sel, output timeout);
endinterface

//--- csf_watchdog.sv
// Watchdog prescaler and overflow counter
`timescale 1ns/1ps
module csf_watchdog #(
	parameter int CNT_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	csf_wdt_if.timer wd
);
	logic [csf_pkg::PRE_W-1:0] pre_q;
	logic [csf_pkg::PRE_W-1:0] mask;
	logic [CNT_W-1:0] cnt_q;
	logic tick;

	// Ratio 2**sel: 1 for sel 0, up to 128 for sel 7
	assign mask = csf_pkg::PRE_W'((8'h01 << wd.prescale_sel) - 8'h01);
	assign tick = (pre_q & mask) == mask;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= '0;
		end else if (ce) begin
			pre_q <= wd.clear ? '0 : pre_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			wd.timeout <= 1'b0;
		end else if (ce) begin
			wd.timeout <= 1'b0;
			if (wd.clear) begin
				cnt_q <= '0;
			end else if (tick) begin
				cnt_q <= cnt_q + 1'b1;
				wd.timeout <= &cnt_q;
			end
		end
	end

	a_wdt_overflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && !wd.clear && tick && (&cnt_q) |=> wd.timeout && cnt_q == '0)
		else $error("watchdog overflow gave no timeout");
endmodule

//--- csf_core_sfr.sv
// Core special-function register bank of an 8-bit controller
//
// What this block does
// - Writing the counter low byte jumps within the current program page.
// - A counter low byte write inserts one dummy cycle.
// - Table read fetches word at pointer; high part to table high byte.
// - Watchdog overflow issues a device reset.
// - Low three prescale bits pick watchdog divide ratio 1 to 128.
// - Flag writes never change watchdog expiry or power-down flags.
// - Wrap-out flag: add carry, subtract no-borrow; rotates also update it.
// - Nibble-wrap flag: low nibble carry, or no nibble borrow.
// - Nil-result flag follows a zero or nonzero add, subtract or logic result; rotates leave it.
// - Signed-wrap flag: carry into top bit differs from carry out.
// - Power-down flag: cleared by reset and watchdog clear, set by halt.
// - Expiry flag: cleared by reset, watchdog clear, halt; set on timeout.
// - Irq entry and calls never save the flag register.
// - Each irq source has its own writable enable bit.
// - Global irq enable gates all sources.
// - Irq entry clears global enable; return from irq sets it.
// - Direction bit one makes the pin an input, zero an output.
// - Unused locations read as zero.
`timescale 1ns/1ps
module csf_core_sfr #(
	parameter int WDT_W = 8,
	parameter int IRQ_N = 11
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] dm_addr,
	input wire logic dm_wr,
	input wire logic [7:0] dm_wdata,
	input wire logic dm_rd,
	output logic [7:0] dm_rdata_q,
	input wire logic pc_load,
	input wire logic [csf_pkg::PC_W-1:0] pc_load_val,
	input wire logic pc_inc,
	output logic [csf_pkg::PC_W-1:0] pc_q,
	output logic stall_q,
	input wire logic tblrd_req,
	output logic [csf_pkg::PC_W-1:0] pm_addr_q,
	output logic pm_rd_q,
	input wire logic [csf_pkg::PM_W-1:0] pm_data,
	output logic [7:0] tbl_low_q,
	output logic tbl_low_valid_q,
	input wire logic alu_valid,
	input wire csf_pkg::csf_alu_t alu_kind,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_result,
	input wire logic rot_carry,
	input wire logic halt,
	input wire logic watchdog_clear_instr,
	input wire logic return_from_irq,
	input wire logic [IRQ_N-1:0] irq_src,
	output logic irq_take_q,
	output logic global_irq_enable_q,
	output logic wdt_reset_q,
	output logic [7:0] port_a_direction_q,
	output logic [7:0] port_b_direction_q,
	output logic [7:0] port_c_direction_q,
	output logic [7:0] port_d_direction_q
);
	// Returns {carry out, nibble carry, signed wrap} of a + b + cin
	function automatic logic [2:0] add_flags(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [7:0] top;
		logic [8:0] full;
		lo = {1'b0, a[csf_pkg::NIBBLE-1:0]} + {1'b0, b[csf_pkg::NIBBLE-1:0]} + {4'h0, cin};
		top = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		add_flags = {full[8], lo[csf_pkg::NIBBLE], top[7] ^ full[8]};
	endfunction
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] loc);
		hit = addr == loc;
	endfunction

	logic [7:0] table_pointer_q;
	logic [6:0] table_high_byte_q;
	logic [7:0] watchdog_prescale_select_q;
	logic [7:1] irq_control_first_q;
	logic [7:0] irq_control_second_q;
	logic [7:0] multi_function_irq_control_q;
	logic carry_q, nibble_wrap_flag_q, nil_flag_q, signed_wrap_flag_q;
	logic powerdown_flag_q, watchdog_expiry_flag_q;
	csf_pkg::csf_tbl_t tbl_q;
	logic [7:0] flags_rd, rd_d;
	logic [IRQ_N-1:0] irq_en;
	logic irq_want;
	logic [2:0] af;
	logic wr_pc_low, wr_stat;

	csf_wdt_if wd ();
	csf_watchdog #(
		.CNT_W(WDT_W)
	) u_wdt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.wd(wd)
	);

	assign wd.clear = ce && watchdog_clear_instr;
	assign wd.prescale_sel = watchdog_prescale_select_q[csf_pkg::PRE_SEL_W-1:0];

	assign wr_pc_low = dm_wr && hit(dm_addr, csf_pkg::A_PC_LOW);
	assign wr_stat = dm_wr && hit(dm_addr, csf_pkg::A_STAT);
	// Subtraction is a + ~b + 1, so carry out means no borrow
	assign af = (alu_kind == csf_pkg::ALU_SUB) ? add_flags(alu_a, ~alu_b, 1'b1)
		: add_flags(alu_a, alu_b, 1'b0);
	// Program counter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= '0;
			stall_q <= 1'b0;
		end else if (ce) begin
			stall_q <= wr_pc_low;
			if (wr_pc_low) begin
				pc_q[7:0] <= dm_wdata;
			end else if (pc_load) begin
				pc_q <= pc_load_val;
			end else if (pc_inc && !stall_q) begin
				pc_q <= pc_q + 1'b1;
			end
		end
	end

	// Plain software registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer_q <= csf_pkg::RST_ZERO;
			watchdog_prescale_select_q <= csf_pkg::RST_WD_PRESCALE;
			irq_control_first_q <= csf_pkg::RST_ZERO[7:1];
			irq_control_second_q <= csf_pkg::RST_ZERO;
			multi_function_irq_control_q <= csf_pkg::RST_ZERO;
			port_a_direction_q <= csf_pkg::RST_DIR;
			port_b_direction_q <= csf_pkg::RST_DIR;
			port_c_direction_q <= csf_pkg::RST_DIR;
			port_d_direction_q <= csf_pkg::RST_DIR;
		end else if (ce && dm_wr) begin
			if (hit(dm_addr, csf_pkg::A_TBL_PTR)) begin
				table_pointer_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_WD_PRESCALE)) begin
				watchdog_prescale_select_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_IRQ0)) begin
				irq_control_first_q <= dm_wdata[7:1];
			end
			if (hit(dm_addr, csf_pkg::A_IRQ1)) begin
				irq_control_second_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_IRQM)) begin
				multi_function_irq_control_q <= dm_wdata;
			end
			// A one bit releases the pin driver; change is allowed at any time
			if (hit(dm_addr, csf_pkg::A_DIRA)) begin
				port_a_direction_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_DIRB)) begin
				port_b_direction_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_DIRC)) begin
				port_c_direction_q <= dm_wdata;
			end
			if (hit(dm_addr, csf_pkg::A_DIRD)) begin
				port_d_direction_q <= dm_wdata;
			end
		end
	end

	// Table read: one cycle to present the address, data captured the next
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tbl_q <= csf_pkg::TBL_IDLE;
			pm_addr_q <= '0;
			pm_rd_q <= 1'b0;
			table_high_byte_q <= '0;
			tbl_low_q <= csf_pkg::RST_ZERO;
			tbl_low_valid_q <= 1'b0;
		end else if (ce) begin
			tbl_low_valid_q <= 1'b0;
			unique case (tbl_q)
				csf_pkg::TBL_IDLE: begin
					if (tblrd_req) begin
						pm_addr_q <= {pc_q[csf_pkg::PC_W-1:8], table_pointer_q};
						pm_rd_q <= 1'b1;
						tbl_q <= csf_pkg::TBL_FETCH;
					end
				end
				csf_pkg::TBL_FETCH: begin
					table_high_byte_q <= pm_data[csf_pkg::PM_W-1:8];
					tbl_low_q <= pm_data[7:0];
					tbl_low_valid_q <= 1'b1;
					pm_rd_q <= 1'b0;
					tbl_q <= csf_pkg::TBL_IDLE;
				end
			endcase
		end
	end

	// Arithmetic flags; an ALU update in the same cycle beats a software write.
	// Irq entry and calls have no path into these flops.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_q <= 1'b0;
			nibble_wrap_flag_q <= 1'b0;
			nil_flag_q <= 1'b0;
			signed_wrap_flag_q <= 1'b0;
		end else if (ce) begin
			if (alu_valid) begin
				unique case (alu_kind)
					csf_pkg::ALU_ADD, csf_pkg::ALU_SUB: begin
						carry_q <= af[2];
						nibble_wrap_flag_q <= af[1];
						signed_wrap_flag_q <= af[0];
						nil_flag_q <= alu_result == '0;
					end
					csf_pkg::ALU_LOGIC: begin
						nil_flag_q <= alu_result == '0;
					end
					csf_pkg::ALU_ROT: begin
						carry_q <= rot_carry;
					end
				endcase
			end else if (wr_stat) begin
				carry_q <= dm_wdata[csf_pkg::F_C];
				nibble_wrap_flag_q <= dm_wdata[csf_pkg::F_NIB_WRAP];
				nil_flag_q <= dm_wdata[csf_pkg::F_Z];
				signed_wrap_flag_q <= dm_wdata[csf_pkg::F_SGN_WRAP];
			end
		end
	end

	// System flags ignore data writes; a setting event beats a clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			powerdown_flag_q <= 1'b0;
			watchdog_expiry_flag_q <= 1'b0;
		end else if (ce) begin
			if (halt) begin
				powerdown_flag_q <= 1'b1;
			end else if (watchdog_clear_instr) begin
				powerdown_flag_q <= 1'b0;
			end
			if (wd.timeout) begin
				watchdog_expiry_flag_q <= 1'b1;
			end else if (watchdog_clear_instr || halt) begin
				watchdog_expiry_flag_q <= 1'b0;
			end
		end
	end

	// The timeout pulse is registered once more so every output is a flop
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_reset_q <= 1'b0;
		end else if (ce) begin
			wdt_reset_q <= wd.timeout;
		end
	end
	// Interrupt entry
	assign irq_en = IRQ_N'({multi_function_irq_control_q[3:0], irq_control_second_q[3:0],
		irq_control_first_q[3:1]});
	assign irq_want = global_irq_enable_q && |(irq_src & irq_en);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			global_irq_enable_q <= 1'b0;
			irq_take_q <= 1'b0;
		end else if (ce) begin
			irq_take_q <= irq_want && !irq_take_q;
			if (irq_want && !irq_take_q) begin
				global_irq_enable_q <= 1'b0;
			end else if (return_from_irq) begin
				global_irq_enable_q <= 1'b1;
			end else if (dm_wr && hit(dm_addr, csf_pkg::A_IRQ0)) begin
				global_irq_enable_q <= dm_wdata[csf_pkg::F_GIE];
			end
		end
	end

	// Read path
	always_comb begin
		flags_rd = csf_pkg::RST_ZERO;
		flags_rd[csf_pkg::F_C] = carry_q;
		flags_rd[csf_pkg::F_NIB_WRAP] = nibble_wrap_flag_q;
		flags_rd[csf_pkg::F_Z] = nil_flag_q;
		flags_rd[csf_pkg::F_SGN_WRAP] = signed_wrap_flag_q;
		flags_rd[csf_pkg::F_PWR_DOWN] = powerdown_flag_q;
		flags_rd[csf_pkg::F_WD_EXPIRY] = watchdog_expiry_flag_q;
	end
	always_comb begin
		unique case (dm_addr)
			csf_pkg::A_PC_LOW: rd_d = pc_q[7:0];
			csf_pkg::A_TBL_PTR: rd_d = table_pointer_q;
			csf_pkg::A_TBL_HIGH: rd_d = {1'b0, table_high_byte_q};
			csf_pkg::A_WD_PRESCALE: rd_d = watchdog_prescale_select_q;
			csf_pkg::A_STAT: rd_d = flags_rd;
			csf_pkg::A_IRQ0: rd_d = {irq_control_first_q, global_irq_enable_q};
			csf_pkg::A_IRQ1: rd_d = irq_control_second_q;
			csf_pkg::A_IRQM: rd_d = multi_function_irq_control_q;
			csf_pkg::A_DIRA: rd_d = port_a_direction_q;
			csf_pkg::A_DIRB: rd_d = port_b_direction_q;
			csf_pkg::A_DIRC: rd_d = port_c_direction_q;
			csf_pkg::A_DIRD: rd_d = port_d_direction_q;
			default: rd_d = csf_pkg::UNUSED_RD;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dm_rdata_q <= csf_pkg::RST_ZERO;
		end else if (ce && dm_rd) begin
			dm_rdata_q <= rd_d;
		end
	end
	a_low_byte_jump: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && wr_pc_low |=> pc_q == {$past(pc_q[csf_pkg::PC_W-1:8]), $past(dm_wdata)})
		else $error("low byte write did not jump in page");
	a_low_byte_dummy: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && wr_pc_low ##1 ce && !wr_pc_low && !pc_load |-> stall_q ##1 pc_q == $past(pc_q))
		else $error("no dummy cycle after low byte write");
	a_table_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && tbl_q == csf_pkg::TBL_IDLE && tblrd_req ##1 ce |=>
		tbl_low_valid_q && table_high_byte_q == $past(pm_data[csf_pkg::PM_W-1:8]))
		else $error("table read result missing");
	a_wdt_reset_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && wd.timeout |=> wdt_reset_q && watchdog_expiry_flag_q)
		else $error("timeout did not reset or flag");
	a_flag_write_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && wr_stat && !halt && !watchdog_clear_instr && !wd.timeout |=>
		$stable(powerdown_flag_q) && $stable(watchdog_expiry_flag_q))
		else $error("flag write touched system flags");
	a_carry_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && alu_valid && alu_kind == csf_pkg::ALU_ADD |=>
		carry_q == $past(({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0FF))
		else $error("carry flag wrong after add");
	a_nibble_sub: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && alu_valid && alu_kind == csf_pkg::ALU_SUB |=>
		nibble_wrap_flag_q == $past(alu_a[3:0] >= alu_b[3:0]))
		else $error("nibble flag wrong after subtract");
	a_nil_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && alu_valid && alu_kind != csf_pkg::ALU_ROT |=>
		nil_flag_q == ($past(alu_result) == 8'h00))
		else $error("nil flag wrong");
	a_signed_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && alu_valid && alu_kind == csf_pkg::ALU_ADD |=> signed_wrap_flag_q ==
		$past((alu_a[7] == alu_b[7]) && ((alu_a + alu_b) >> 7 != {7'h00, alu_a[7]})))
		else $error("signed wrap flag wrong");
	a_pdf_halt_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && (halt || watchdog_clear_instr) |=> powerdown_flag_q == $past(halt))
		else $error("power-down flag wrong");
	a_expiry_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && (halt || watchdog_clear_instr) && !wd.timeout |=> !watchdog_expiry_flag_q)
		else $error("expiry flag not cleared");
	a_irq_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(irq_take_q) |-> !global_irq_enable_q && $past(global_irq_enable_q))
		else $error("irq taken without global enable");
	a_return_from_irq_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && return_from_irq && !irq_want |=> global_irq_enable_q)
		else $error("return did not re-enable");
	a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && dm_rd && dm_addr > csf_pkg::A_IRQM |=> dm_rdata_q == 8'h00)
		else $error("unused location read nonzero");
endmodule

//--- tb_top.sv
// Self-checking bench for the core special-function register bank
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, rst_n, ce, dm_wr, dm_rd, pc_load, pc_inc, tblrd_req, alu_valid;
	logic rot_carry, halt, watchdog_clear_instr, return_from_irq, stall_q, pm_rd_q, tbl_low_valid_q;
	logic irq_take_q, global_irq_enable_q, wdt_reset_q, rd_seen;
	logic [7:0] dm_addr, dm_wdata, dm_rdata_q, alu_a, alu_b, alu_result, tbl_low_q, fl;
	logic [7:0] port_a_direction_q, port_b_direction_q, port_c_direction_q, port_d_direction_q;
	logic [11:0] pc_load_val, pc_q, pm_addr_q;
	logic [14:0] pm_data;
	logic [10:0] irq_src;
	logic [15:0] lfsr;
	csf_pkg::csf_alu_t alu_kind;
	logic [7:0] exp_q[$];
	int err_count = 0;
	int samples_checked = 0;
	logic [15:0] rst_tab[8] = '{16'h13FF, 16'h15FF, 16'h17FF, 16'h19FF, 16'h0907, 16'h0A00,
		16'h0C00, 16'h4000};
	logic [7:0] dir_addr[4] = '{8'h13, 8'h15, 8'h17, 8'h19};
	logic [7:0] en_addr[3] = '{8'h0B, 8'h1E, 8'h1F};
	logic [7:0] en_val[3] = '{8'h02, 8'h01, 8'h01};
	int src_bit[3] = '{0, 3, 7};

	csf_core_sfr #(.WDT_W(8), .IRQ_N(11)) dut_u (.ref_clk, .rst_n, .ce, .dm_addr, .dm_wr,
		.dm_wdata, .dm_rd, .dm_rdata_q, .pc_load, .pc_load_val, .pc_inc, .pc_q, .stall_q,
		.tblrd_req, .pm_addr_q, .pm_rd_q, .pm_data, .tbl_low_q, .tbl_low_valid_q, .alu_valid,
		.alu_kind, .alu_a, .alu_b, .alu_result, .rot_carry, .halt, .watchdog_clear_instr, .return_from_irq,
		.irq_src, .irq_take_q, .global_irq_enable_q, .wdt_reset_q, .port_a_direction_q,
		.port_b_direction_q, .port_c_direction_q, .port_d_direction_q);

	// Outside a fetch the memory shows the inverse, so a late sample cannot match
	assign pm_data = pm_rd_q ? {pm_addr_q[2:0], pm_addr_q} : {3'h7, ~pm_addr_q};

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: address %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// Read data lands on the read edge; compare it half a cycle later
	always @(posedge ref_clk) rd_seen <= dm_rd & ce & rst_n;
	always @(negedge ref_clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) chk8(dm_rdata_q, 8'hEE);
			else chk8(dm_rdata_q, exp_q.pop_front());
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		dm_wr <= 1'b1;
		dm_addr <= a;
		dm_wdata <= d;
		@(posedge ref_clk);
		dm_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		dm_rd <= 1'b1;
		dm_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
		dm_rd <= 1'b0;
	endtask

	task automatic pulse(input int k);
		@(posedge ref_clk);
		{halt, watchdog_clear_instr, return_from_irq, tblrd_req} <= 4'h8 >> k;
		@(posedge ref_clk);
		{halt, watchdog_clear_instr, return_from_irq, tblrd_req} <= 4'h0;
	endtask

	task automatic alu(input csf_pkg::csf_alu_t k, input logic [7:0] a, input logic [7:0] b,
		input logic rc);
		logic [7:0] bb;
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] m;
		logic [7:0] r;
		logic ci;
		ci = (k == csf_pkg::ALU_SUB);
		bb = ci ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		m = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
		r = (k == csf_pkg::ALU_LOGIC) ? (a & b) : s[7:0];
		if (k == csf_pkg::ALU_ADD || k == csf_pkg::ALU_SUB) fl[3:0] = {m[7] ^ s[8], r == 8'h00, n[4], s[8]};
		else if (k == csf_pkg::ALU_LOGIC) fl[2] = (r == 8'h00);
		else fl[0] = rc;
		@(posedge ref_clk);
		alu_valid <= 1'b1;
		alu_kind <= k;
		alu_a <= a;
		alu_b <= b;
		alu_result <= r;
		rot_carry <= rc;
		@(posedge ref_clk);
		alu_valid <= 1'b0;
		rd(8'h0A, fl);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("ERROR %0t: run did not finish", $time);
		results();
	end

	initial begin
		logic [7:0] v;
		logic [7:0] va;
		int n;
		{rst_n, dm_wr, dm_rd, pc_load, pc_inc, tblrd_req, alu_valid} = '0;
		{rot_carry, halt, watchdog_clear_instr, return_from_irq} = '0;
		{dm_addr, dm_wdata, alu_a, alu_b, alu_result, pc_load_val, irq_src} = '0;
		alu_kind = csf_pkg::ALU_ADD;
		ce = 1'b1;
		fl = 8'h00;
		lfsr = 16'hDEE0;
		va = 8'h00;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
		$display("test reset values done");

		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			v = lfsr[7:0];
			if (i == 0) va = v;
			wr(dir_addr[i], v);
			@(negedge ref_clk);
			chk8(i == 0 ? port_a_direction_q : i == 1 ? port_b_direction_q :
				i == 2 ? port_c_direction_q : port_d_direction_q, v);
			rd(dir_addr[i], v);
		end
		// A write with the clock enable low must not land
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(8'h13, ~va);
		ce <= 1'b1;
		@(negedge ref_clk);
		chk8(port_a_direction_q, va);
		$display("test direction done");

		@(posedge ref_clk);
		pc_load <= 1'b1;
		pc_load_val <= 12'hA12;
		@(posedge ref_clk);
		pc_load <= 1'b0;
		pc_inc <= 1'b1;
		dm_wr <= 1'b1;
		dm_addr <= 8'h06;
		dm_wdata <= 8'h55;
		@(posedge ref_clk);
		dm_wr <= 1'b0;
		@(negedge ref_clk);
		chk12(pc_q, 12'hA55);
		chk1(stall_q, 1'b1);
		@(negedge ref_clk);
		chk12(pc_q, 12'hA55);
		chk1(stall_q, 1'b0);
		@(posedge ref_clk);
		pc_inc <= 1'b0;
		@(negedge ref_clk);
		chk12(pc_q, 12'hA56);
		rd(8'h06, 8'h56);
		$display("test program counter done");

		for (int i = 0; i < 2; i++) begin
			lfsr = lfsr_next(lfsr);
			v = lfsr[7:0];
			wr(8'h07, v);
			pulse(3);
			@(negedge ref_clk);
			chk12(pm_addr_q, {4'hA, v});
			chk1(pm_rd_q, 1'b1);
			@(negedge ref_clk);
			chk1(tbl_low_valid_q, 1'b1);
			chk8(tbl_low_q, v);
			wr(8'h08, 8'hFF);
			rd(8'h08, {1'b0, v[2:0], 4'hA});
		end
		$display("test table read done");

		alu(csf_pkg::ALU_ADD, 8'hFF, 8'h01, 1'b0);
		alu(csf_pkg::ALU_ADD, 8'h7F, 8'h01, 1'b0);
		alu(csf_pkg::ALU_SUB, 8'h80, 8'h01, 1'b0);
		alu(csf_pkg::ALU_SUB, 8'h10, 8'h20, 1'b0);
		alu(csf_pkg::ALU_LOGIC, 8'hF0, 8'h0F, 1'b0);
		alu(csf_pkg::ALU_ROT, 8'h00, 8'h00, 1'b1);
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			alu(lfsr[0] ? csf_pkg::ALU_SUB : csf_pkg::ALU_ADD, lfsr[7:0], lfsr[15:8], 1'b0);
		end
		wr(8'h0A, 8'hFF);
		fl[3:0] = 4'hF;
		rd(8'h0A, fl);
		pulse(0);
		fl[5:4] = 2'b01;
		rd(8'h0A, fl);
		wr(8'h0A, 8'h00);
		fl[3:0] = 4'h0;
		rd(8'h0A, fl);
		pulse(1);
		fl[5:4] = 2'b00;
		rd(8'h0A, fl);
		$display("test flags done");

		for (int i = 0; i < 3; i++) begin
			wr(8'h0B, 8'h00);
			wr(en_addr[i], en_val[i]);
			@(posedge ref_clk);
			irq_src <= 11'h001 << src_bit[i];
			repeat (3) @(negedge ref_clk);
			chk1(irq_take_q, 1'b0);
			wr(8'h0B, 8'h01 | en_val[i] & {8{i == 0}});
			n = 0;
			while (irq_take_q !== 1'b1 && n < 5) begin
				@(negedge ref_clk);
				n++;
			end
			chk1(irq_take_q, 1'b1);
			chk1(global_irq_enable_q, 1'b0);
			rd(en_addr[i], en_val[i]);
			rd(8'h0A, fl);
			irq_src <= 11'h000;
			pulse(2);
			@(negedge ref_clk);
			chk1(global_irq_enable_q, 1'b1);
			wr(en_addr[i], 8'h00);
		end
		$display("test interrupts done");

		// Upper prescale bits are set to show that they do not alter the ratio
		for (int i = 0; i < 2; i++) begin
			wr(8'h09, 8'hF8 | i[7:0]);
			pulse(1);
			n = 0;
			while (wdt_reset_q !== 1'b1 && n < 2000) begin
				@(negedge ref_clk);
				n++;
			end
			chk1(n >= (256 << i) - 2 && n <= (256 << i) + 6, 1'b1);
			fl[5] = 1'b1;
			rd(8'h0A, fl);
		end
		pulse(1);
		fl[5] = 1'b0;
		rd(8'h0A, fl);
		$display("test watchdog done");
		repeat (2) @(posedge ref_clk);
		chk1(exp_q.size() == 0, 1'b1);
		results();
	end
endmodule
